/* logic/quad_dac_i2c_command_slave.sv */
// two-wire command slave with double-buffered quad dac registers
// Behaviour
// - cmd 0001 writes input regs; low strobe, unmasked, makes dac follow input
// - cmd 0010 copies selected input registers into dac registers
// - cmd 0011 writes input and dac registers regardless of strobe
// - bus address is 00011 followed by the two select pins
// - grounded select pin gives 0, pin at supply gives 1
// - matched address acknowledged low on ninth pulse; others stay idle
// - bytes are eight bits plus acknowledge; data changes only while clock low
// - write frame: address, command, high byte, low byte, all acknowledged
// - read: address and command, repeated start, address with read, data bytes
// - several channels selected for readback returns channel a
// - readback sends input registers msb first, auto-incrementing until nack
// - after channel d readback continues with channel a
// - cmd 0100 loads two power-down bits per channel from the low byte
// - code 00 normal, 01 one kilohm, 10 hundred kilohm, 11 three-state
// - nonzero code powers the channel down to its termination
// - power-down keeps dac registers and still accepts writes
// - output counts valid only after recovery time leaving power-down
// - each channel holds input and dac registers; strobe governs transfer
// - write frame is 4-bit command, 4 select bits, 16-bit data word
// - strobe falling edge copies input to dac on unmasked channels
// - cmd 0101 loads strobe mask from data bits 3:0
module quad_dac_i2c_command_slave (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_select_hi_i,
  input wire logic addr_select_lo_i,
  input wire logic load_strobe_n_i,
  output dac_i2c_pkg::word_t dac_value_o [4],
  output logic [3:0][1:0] pd_mode_o,
  output logic [3:0] load_mask_o,
  output logic [3:0] out_valid_o
);
  dac_i2c_pkg::link_frame_s f_reg, f_next;
  dac_i2c_pkg::link_keep_s k_reg, k_next;
  dac_i2c_pkg::core_s c_reg, c_next;
  logic oe_reg, oe_next;
  logic [7:0] rx;
  logic [7:0] tx_byte;
  logic start, stop, exec, ld_fall;
  dac_i2c_pkg::frame_s fr;

  // ---------------- link side, clocked by scl ----------------
  always_comb
  begin
    f_next = f_reg;
    k_next = k_reg;
    rx = {f_reg.shift[6:0], sda_i};
    k_next.snap_m = c_reg.snap_tog;
    k_next.snap_s = k_reg.snap_m;
    k_next.snap_d = k_reg.snap_s;
    k_next.asel_m = {addr_select_hi_i, addr_select_lo_i};
    k_next.asel_s = k_reg.asel_m;
    if (k_reg.snap_s != k_reg.snap_d)
    begin
      k_next.in_copy = c_reg.in_reg;
    end
    if (f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK)
    begin
      f_next.bit_cnt = '0;
      if (f_reg.rd && f_reg.byte_cnt > dac_i2c_pkg::BYTE_CMD)
      begin
        f_next.lo_half = ~f_reg.lo_half;
        if (sda_i)
        begin
          f_next.tx_on = 1'b0;
        end
        if (f_reg.lo_half)
        begin
          k_next.ptr = k_reg.ptr + 2'h1;
        end
      end
    end
    else
    begin
      f_next.shift = rx;
      f_next.bit_cnt = f_reg.bit_cnt + 4'h1;
      if (f_reg.bit_cnt == dac_i2c_pkg::BIT_LAST)
      begin
        if (f_reg.byte_cnt != dac_i2c_pkg::BYTE_SAT)
        begin
          f_next.byte_cnt = f_reg.byte_cnt + 3'h1;
        end
        if (f_reg.byte_cnt == dac_i2c_pkg::BYTE_ADDR)
        begin
          f_next.addr_ok = (rx[7:1] == {dac_i2c_pkg::ADDR_FIXED, k_reg.asel_s});
          f_next.rd = rx[0];
          f_next.tx_on = rx[0];
          f_next.lo_half = 1'b0;
        end
        else if (f_reg.addr_ok && !f_reg.rd)
        begin
          unique case (f_reg.byte_cnt)
            dac_i2c_pkg::BYTE_CMD:
            begin
              f_next.cmd_byte = rx;
              unique case (rx[3:0])
                4'h2: k_next.ptr = 2'h1;
                4'h4: k_next.ptr = 2'h2;
                4'h8: k_next.ptr = 2'h3;
                default: k_next.ptr = 2'h0;
              endcase
            end
            dac_i2c_pkg::BYTE_HI: f_next.hi_byte = rx;
            dac_i2c_pkg::BYTE_LO:
            begin
              k_next.frame = {f_reg.cmd_byte, f_reg.hi_byte, rx};
              k_next.frame_tog = ~k_reg.frame_tog;
            end
            default: f_next.byte_cnt = dac_i2c_pkg::BYTE_SAT;
          endcase
        end
      end
    end
  end

  always_ff @(posedge scl_i or posedge c_reg.frame_rst)
  begin
    if (c_reg.frame_rst)
    begin
      f_reg <= '0;
    end
    else
    begin
      f_reg <= f_next;
    end
  end

  always_ff @(posedge scl_i or posedge c_reg.link_rst)
  begin
    if (c_reg.link_rst)
    begin
      k_reg <= '0;
    end
    else
    begin
      k_reg <= k_next;
    end
  end

  // sda changes only on the falling scl edge
  always_comb
  begin
    tx_byte = f_reg.lo_half ? k_reg.in_copy[k_reg.ptr][7:0] : k_reg.in_copy[k_reg.ptr][15:8];
    oe_next = 1'b0;
    if (f_reg.addr_ok)
    begin
      if (f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK)
      begin
        oe_next = !f_reg.rd || f_reg.byte_cnt == dac_i2c_pkg::BYTE_CMD;
      end
      else if (f_reg.rd && f_reg.tx_on && f_reg.byte_cnt != dac_i2c_pkg::BYTE_ADDR)
      begin
        oe_next = ~tx_byte[3'(dac_i2c_pkg::BIT_LAST - f_reg.bit_cnt)];
      end
    end
  end

  always_ff @(negedge scl_i or posedge c_reg.frame_rst)
  begin
    if (c_reg.frame_rst)
    begin
      oe_reg <= 1'b0;
    end
    else
    begin
      oe_reg <= oe_next;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_reg;

  // ---------------- core side, clocked by clk ----------------
  assign start = c_reg.scl_s && c_reg.sda_d && !c_reg.sda_s;
  assign stop = c_reg.scl_s && !c_reg.sda_d && c_reg.sda_s;
  assign exec = c_reg.tog_s != c_reg.tog_d;
  assign ld_fall = c_reg.ld_d && !c_reg.ld_s;
  assign fr = k_reg.frame;

  always_comb
  begin
    c_next = c_reg;
    c_next.scl_m = scl_i;
    c_next.scl_s = c_reg.scl_m;
    c_next.sda_m = sda_i;
    c_next.sda_s = c_reg.sda_m;
    c_next.sda_d = c_reg.sda_s;
    c_next.tog_m = k_reg.frame_tog;
    c_next.tog_s = c_reg.tog_m;
    c_next.tog_d = c_reg.tog_s;
    c_next.ld_m = load_strobe_n_i;
    c_next.ld_s = c_reg.ld_m;
    c_next.ld_d = c_reg.ld_s;
    c_next.frame_rst = start || stop;
    c_next.link_rst = 1'b0;
    if (exec)
    begin
      unique case (fr.cmd)
        dac_i2c_pkg::CMD_PWR: c_next.pd = fr.data[7:0];
        dac_i2c_pkg::CMD_MASK: c_next.mask = fr.data[3:0];
        dac_i2c_pkg::CMD_WR_IN, dac_i2c_pkg::CMD_WR_UPD:
        begin
          c_next.snap_tog = c_reg.snap_tog ^ (|fr.sel);
        end
        default: c_next.snap_tog = c_reg.snap_tog;
      endcase
    end
    for (int ch = 0; ch < 4; ch++)
    begin
      if (exec && fr.sel[ch])
      begin
        unique case (fr.cmd)
          dac_i2c_pkg::CMD_WR_IN: c_next.in_reg[ch] = fr.data;
          dac_i2c_pkg::CMD_UPD: c_next.dac_reg[ch] = c_reg.in_reg[ch];
          dac_i2c_pkg::CMD_WR_UPD:
          begin
            c_next.in_reg[ch] = fr.data;
            c_next.dac_reg[ch] = fr.data;
          end
          default: c_next.in_reg[ch] = c_reg.in_reg[ch];
        endcase
      end
      // transparent while strobe low, edge load on its fall
      if (!c_reg.mask[ch] && (!c_reg.ld_s || ld_fall))
      begin
        c_next.dac_reg[ch] = c_next.in_reg[ch];
      end
      if (c_reg.pd[ch] != 2'h0)
      begin
        c_next.rec_cnt[ch] = dac_i2c_pkg::RECOVERY_LOAD;
      end
      else if (c_reg.rec_cnt[ch] != '0)
      begin
        c_next.rec_cnt[ch] = c_reg.rec_cnt[ch] - 9'h001;
      end
      c_next.valid[ch] = c_reg.pd[ch] == 2'h0 && c_reg.rec_cnt[ch] == '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      c_reg <= '0;
      c_reg.frame_rst <= 1'b1;
      c_reg.link_rst <= 1'b1;
      c_reg.scl_m <= 1'b1;
      c_reg.scl_s <= 1'b1;
      c_reg.sda_m <= 1'b1;
      c_reg.sda_s <= 1'b1;
      c_reg.sda_d <= 1'b1;
      c_reg.ld_m <= 1'b1;
      c_reg.ld_s <= 1'b1;
      c_reg.ld_d <= 1'b1;
      c_reg.valid <= 4'hF;
    end
    else
    begin
      c_reg <= c_next;
    end
  end

  for (genvar g = 0; g < 4; g++)
  begin : g_out
    assign dac_value_o[g] = c_reg.dac_reg[g];
  end
  assign pd_mode_o = c_reg.pd;
  assign load_mask_o = c_reg.mask;
  assign out_valid_o = c_reg.valid;

  // ---------------- checks ----------------
  a_pd_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_PWR |=> c_reg.pd == $past(fr.data[7:0]))
    else $error("power-down codes not loaded");
  a_mask_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_MASK |=> c_reg.mask == $past(fr.data[3:0]))
    else $error("strobe mask not loaded");
  a_input_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_WR_IN && fr.sel[0] |=> c_reg.in_reg[0] == $past(fr.data))
    else $error("input register a not written");
  a_dac_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_UPD && fr.sel[1] |=> c_reg.dac_reg[1] == $past(c_reg.in_reg[1]))
    else $error("dac register b not updated");
  a_write_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_WR_UPD && fr.sel[2] |=> c_reg.dac_reg[2] == $past(fr.data))
    else $error("dac register c not written");
  a_strobe_load: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ld_fall && !c_reg.mask[3] |=> c_reg.dac_reg[3] == $past(c_reg.in_reg[3]))
    else $error("strobe edge did not load dac d");
  a_mask_holds: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    c_reg.mask[0] && !exec |=> $stable(c_reg.dac_reg[0]))
    else $error("masked channel followed strobe");
  a_reserved_cmd: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd > dac_i2c_pkg::CMD_MASK |=> $stable(c_reg.in_reg) && $stable(c_reg.pd) && $stable(c_reg.mask))
    else $error("reserved command changed state");
  a_pd_recovery: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $fell(c_reg.pd[0] != 2'h0) |-> !c_reg.valid[0] [*8])
    else $error("output valid before recovery");
  a_addr_ack: assert property (@(posedge scl_i) disable iff (c_reg.frame_rst)
    f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK && f_reg.byte_cnt == dac_i2c_pkg::BYTE_CMD && f_reg.addr_ok |-> sda_oe_o)
    else $error("address not acknowledged");
  a_no_foreign: assert property (@(posedge scl_i) disable iff (c_reg.frame_rst)
    f_reg.byte_cnt != dac_i2c_pkg::BYTE_ADDR && !f_reg.addr_ok |-> !sda_oe_o)
    else $error("drove bus for foreign address");
  a_ptr_wrap: assert property (@(posedge scl_i) disable iff (c_reg.link_rst)
    k_reg.ptr == 2'h3 && f_reg.rd && f_reg.lo_half && f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK
    && f_reg.byte_cnt > dac_i2c_pkg::BYTE_CMD && !c_reg.frame_rst |=> k_reg.ptr == 2'h0)
    else $error("readback pointer did not wrap");
  a_read_no_ack: assert property (@(posedge scl_i) disable iff (c_reg.frame_rst)
    f_reg.rd && f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK && f_reg.byte_cnt > dac_i2c_pkg::BYTE_CMD |-> !sda_oe_o)
    else $error("device drove acknowledge of read data");

  // strobe transparency and power-down checks
  a_strobe_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !c_reg.ld_s && !c_reg.mask[1] && !exec |=> c_reg.dac_reg[1] == c_reg.in_reg[1])
    else $error("dac b did not follow input while strobe low");
  a_pd_keeps_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    exec && fr.cmd == dac_i2c_pkg::CMD_WR_UPD && fr.sel[0] && c_reg.pd[0] != 2'h0
    |=> c_reg.dac_reg[0] == $past(fr.data) && c_reg.pd[0] == $past(c_reg.pd[0]))
    else $error("write lost while powered down");
  a_pd_invalid: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    c_reg.pd[2] != 2'h0 |=> !c_reg.valid[2])
    else $error("powered-down channel reported valid");

  // main scenarios

  c_write_frame: cover property (@(posedge clk_i) exec && fr.cmd == dac_i2c_pkg::CMD_WR_IN);
  c_readback: cover property (@(posedge scl_i) f_reg.rd && f_reg.byte_cnt == dac_i2c_pkg::BYTE_SAT);
  c_strobe_edge: cover property (@(posedge clk_i) ld_fall && c_reg.mask != 4'hF);
  c_recovered: cover property (@(posedge clk_i) $rose(c_reg.valid[0]));
  c_ptr_wrap: cover property (@(posedge scl_i)
    k_reg.ptr == 2'h3 && f_reg.lo_half && f_reg.bit_cnt == dac_i2c_pkg::BIT_ACK);
endmodule : quad_dac_i2c_command_slave

/* include/dac_i2c_pkg.sv */
// shared types and constants for the quad dac two-wire command slave
package dac_i2c_pkg;
  typedef logic [15:0] word_t;

  // 24-bit write frame, msb first
  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] sel;
    word_t data;
  } frame_s;

  localparam logic [3:0] CMD_WR_IN = 4'h1;
  localparam logic [3:0] CMD_UPD = 4'h2;
  localparam logic [3:0] CMD_WR_UPD = 4'h3;
  localparam logic [3:0] CMD_PWR = 4'h4;
  localparam logic [3:0] CMD_MASK = 4'h5;

  localparam logic [4:0] ADDR_FIXED = 5'h03;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] BYTE_ADDR = 3'h0;
  localparam logic [2:0] BYTE_CMD = 3'h1;
  localparam logic [2:0] BYTE_HI = 3'h2;
  localparam logic [2:0] BYTE_LO = 3'h3;
  localparam logic [2:0] BYTE_SAT = 3'h4;

  localparam int RECOVERY_NS = 2500;
  localparam int CLK_PERIOD_NS = 5;
  localparam int RECOVERY_CYCLES = (RECOVERY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef logic [8:0] rec_t;
  localparam rec_t RECOVERY_LOAD = rec_t'(RECOVERY_CYCLES);

  // link state cleared by every start or stop
  typedef struct packed {
    logic [3:0] bit_cnt;
    logic [2:0] byte_cnt;
    logic [7:0] shift;
    logic addr_ok;
    logic rd;
    logic lo_half;
    logic tx_on;
    logic [7:0] cmd_byte;
    logic [7:0] hi_byte;
  } link_frame_s;

  // link state kept across frames
  typedef struct packed {
    logic [1:0] ptr;
    frame_s frame;
    logic frame_tog;
    logic snap_m;
    logic snap_s;
    logic snap_d;
    logic [1:0] asel_m;
    logic [1:0] asel_s;
    logic [3:0][15:0] in_copy;
  } link_keep_s;

  // system clock side state
  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic sda_m;
    logic sda_s;
    logic sda_d;
    logic tog_m;
    logic tog_s;
    logic tog_d;
    logic ld_m;
    logic ld_s;
    logic ld_d;
    logic frame_rst;
    logic link_rst;
    logic snap_tog;
    logic [3:0][15:0] in_reg;
    logic [3:0][15:0] dac_reg;
    logic [3:0][1:0] pd;
    logic [3:0] mask;
    logic [3:0][8:0] rec_cnt;
    logic [3:0] valid;
  } core_s;
endpackage : dac_i2c_pkg

/* test/i2c_master_model.sv */
// two-wire bus master model driving the link clock and data
module i2c_master_model (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // start or repeated start; scl stands high between frames
  task automatic start_c();
    sda_low_o = 1'b0;
    #40 scl_o = 1'b1;
    #80 sda_low_o = 1'b1;
    #80 scl_o = 1'b0;
    #40;
  endtask : start_c
  // data moves only while scl low
  task automatic bit_c(input logic b, output logic s);
    sda_low_o = ~b;
    #40 scl_o = 1'b1;
    #40 s = sda_i;
    #40 scl_o = 1'b0;
    #40;
  endtask : bit_c
  task automatic byte_c(input logic [7:0] tx, input logic ak, output logic [7:0] rx, output logic ao);
    for (int i = 7; i >= 0; i--)
      bit_c(tx[i], rx[i]);
    bit_c(ak, ao);
  endtask : byte_c
  task automatic stop_c();
    sda_low_o = 1'b1;
    #40 scl_o = 1'b1;
    #80 sda_low_o = 1'b0;
    #80;
  endtask : stop_c
endmodule : i2c_master_model

/* test/testbench.sv */
// self-checking bench for the quad dac two-wire command slave
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hi_sel = 1'b0;
  logic lo_sel = 1'b0;
  logic strobe_n = 1'b1;
  logic scl;
  logic mst_low;
  logic sda_oe;
  logic sda_lvl;
  logic sda_w;
  dac_i2c_pkg::word_t dac_v [4];
  logic [3:0][1:0] pd;
  logic [3:0] mask;
  logic [3:0] valid;
  logic [15:0] e_in [4] = '{default: 16'h0000};
  logic [15:0] e_dac [4] = '{default: 16'h0000};
  logic [7:0] e_pd = 8'h00;
  logic [3:0] e_mask = 4'h0;
  int fails = 0;
  int compares = 0;
  // open drain wire with pull-up
  assign sda_w = ~((sda_oe & ~sda_lvl) | mst_low);
  always #2.5 clk_i = ~clk_i;
  i2c_master_model i_master (.scl_o(scl), .sda_low_o(mst_low), .sda_i(sda_w));
  quad_dac_i2c_command_slave i_dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_lvl), .sda_oe_o(sda_oe),
    .addr_select_hi_i(hi_sel), .addr_select_lo_i(lo_sel), .load_strobe_n_i(strobe_n),
    .dac_value_o(dac_v), .pd_mode_o(pd), .load_mask_o(mask), .out_valid_o(valid));
  function automatic logic [6:0] own();
    return {5'h03, hi_sel, lo_sel};
  endfunction : own
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic chk_all();
    for (int c = 0; c < 4; c++)
      chk(dac_v[c], e_dac[c], "dac register");
    chk(16'(pd), 16'(e_pd), "power-down codes");
    chk(16'(mask), 16'(e_mask), "strobe mask");
  endtask : chk_all
  task automatic expect_frame(input logic [3:0] cmd, input logic [3:0] sel, input logic [15:0] d);
    for (int c = 0; c < 4; c++)
    begin
      if (sel[c] && (cmd == 4'h1 || cmd == 4'h3)) e_in[c] = d;
      if (sel[c] && (cmd == 4'h2 || cmd == 4'h3)) e_dac[c] = e_in[c];
      if (sel[c] && cmd == 4'h1 && !strobe_n && !e_mask[c]) e_dac[c] = d;
    end
    if (cmd == 4'h4) e_pd = d[7:0];
    if (cmd == 4'h5) e_mask = d[3:0];
  endtask : expect_frame
  task automatic frame(input logic [6:0] a, input logic [3:0] cmd, input logic [3:0] sel, input logic [15:0] d);
    logic [23:0] f;
    logic [7:0] rx;
    logic ak;
    f = {cmd, sel, d};
    i_master.start_c();
    i_master.byte_c({a, 1'b0}, 1'b1, rx, ak);
    chk(16'(ak), 16'(a != own()), "address ack");
    for (int b = 2; b >= 0; b--)
    begin
      i_master.byte_c(f[b*8+:8], 1'b1, rx, ak);
      chk(16'(ak), 16'(a != own()), "byte ack");
    end
    i_master.stop_c();
    if (a == own()) expect_frame(cmd, sel, d);
    repeat (20) @(negedge clk_i);
    chk_all();
  endtask : frame
  task automatic read_back(input logic [3:0] sel, input int words);
    logic [7:0] rx;
    logic [7:0] hi;
    logic ak;
    int ch;
    ch = 0;
    if ($countones(sel) == 1)
      for (int c = 0; c < 4; c++)
        if (sel[c]) ch = c;
    i_master.start_c();
    i_master.byte_c({own(), 1'b0}, 1'b1, rx, ak);
    i_master.byte_c({4'h0, sel}, 1'b1, rx, ak);
    i_master.start_c();
    i_master.byte_c({own(), 1'b1}, 1'b1, rx, ak);
    chk(16'(ak), 16'h0000, "read address ack");
    for (int w = 0; w < words; w++)
    begin
      i_master.byte_c(8'hFF, 1'b0, hi, ak);
      i_master.byte_c(8'hFF, w == words - 1, rx, ak);
      chk({hi, rx}, e_in[ch], "readback word");
      ch = (ch + 1) % 4;
    end
    i_master.stop_c();
    repeat (20) @(negedge clk_i);
  endtask : read_back
  task automatic strobe(input logic lvl);
    @(negedge clk_i) strobe_n = lvl;
    for (int c = 0; c < 4; c++)
      if (!lvl && !e_mask[c]) e_dac[c] = e_in[c];
    repeat (10) @(negedge clk_i);
  endtask : strobe
  task automatic complete_run();
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #400000;
    fails++;
    complete_run();
  end
  initial
  begin
    void'($urandom(32'h9E20));
    repeat (20) @(negedge clk_i);
    sys_rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk_all();
    chk(16'(valid), 16'h000F, "valid after reset");
    for (int k = 0; k < 4; k++)
    begin
      {hi_sel, lo_sel} = 2'(k);
      frame(own() ^ 7'(1 << (2 + $urandom % 5)), 4'h3, 4'hF, 16'($urandom));
      frame(own(), 4'h3, 4'(1 << k), 16'($urandom));
    end
    frame(own(), 4'h1, 4'($urandom) | 4'h1, 16'($urandom));
    read_back(4'h4, 5);
    read_back(4'hB, 1);
    strobe(1'b0);
    strobe(1'b1);
    chk_all();
    frame(own(), 4'h5, 4'($urandom), 16'($urandom));
    frame(own(), 4'h1, 4'hF, 16'($urandom));
    strobe(1'b0);
    strobe(1'b1);
    chk_all();
    frame(own(), 4'h2, 4'($urandom) | 4'h2, 16'h0000);
    frame(own(), 4'h5, 4'hF, 16'h0009);
    strobe(1'b0);
    frame(own(), 4'h1, 4'($urandom) | 4'h6, 16'($urandom));
    strobe(1'b1);
    for (int c = 0; c < 16; c++)
      if (!(c inside {[1:5]}))
        frame(own(), 4'(c), 4'hF, 16'($urandom));
    frame(own(), 4'h4, 4'h0, 16'h001B);
    chk(16'(valid), 16'h0008, "valid in power-down");
    frame(own(), 4'h3, 4'hF, 16'($urandom));
    frame(own(), 4'h4, 4'hF, 16'h0000);
    repeat (300) @(negedge clk_i);
    chk(16'(valid), 16'h0008, "valid in recovery");
    repeat (300) @(negedge clk_i);
    chk(16'(valid), 16'h000F, "valid after recovery");
    complete_run();
  end
endmodule : testbench
